/* File: design/app_pkg.sv */
package app_pkg;

    // Bus shape
    localparam int APB_ADDR_W = 12;
    localparam int DATA_W     = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] CTL_IDX    = 8'hD7;
    localparam logic [7:0] SAMPLE_IDX = 8'hD8;
    localparam logic [7:0] STATUS_IDX = 8'hD9;
    localparam logic [APB_ADDR_W-1:0] CTL_ADDR    = {2'h0, CTL_IDX, 2'h0};
    localparam logic [APB_ADDR_W-1:0] SAMPLE_ADDR = {2'h0, SAMPLE_IDX, 2'h0};
    localparam logic [APB_ADDR_W-1:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

    // Reset values
    localparam logic [7:0] CTL_RESET    = 8'h00;
    localparam logic [7:0] SAMPLE_RESET = 8'h00;

    // Control field layout
    localparam int CTL_ON_BIT   = 0;
    localparam int CTL_PRESC_LO = 2;
    localparam int CTL_PRESC_HI = 3;
    localparam int CTL_WIDE_BIT = 5;
    localparam int CTL_LSB_LO   = 6;
    localparam int CTL_LSB_HI   = 7;

    // Sample layout: sign and magnitude
    localparam int SAMPLE_SIGN_BIT = 7;
    localparam int MAG_W           = 9;

    // Status layout
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_PULSE_BIT = 1;
    localparam int STAT_SIGN_BIT  = 2;

    // Prescaler codes and divisors
    localparam logic [1:0] PRESC_DIV4 = 2'h0;
    localparam logic [1:0] PRESC_DIV6 = 2'h1;
    localparam logic [1:0] PRESC_DIV7 = 2'h2;
    localparam logic [2:0] DIVISOR_4  = 3'h4;
    localparam logic [2:0] DIVISOR_6  = 3'h6;
    localparam logic [2:0] DIVISOR_7  = 3'h7;

    // Period shape
    localparam int PERIOD_W_DEF = 7;
    localparam logic [9:0] PERIOD_CLOCKS_DIV4 = 10'h200;
    localparam logic [9:0] PERIOD_CLOCKS_DIV6 = 10'h300;
    localparam logic [9:0] PERIOD_CLOCKS_DIV7 = 10'h380;

    typedef enum logic [1:0] {
        ST_OFF = 2'b01,
        ST_RUN = 2'b10
    } app_state_t;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_CTL,
        SEL_SAMPLE,
        SEL_STATUS
    } app_reg_sel_t;

    typedef struct packed {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [DATA_W-1:0]     pwdata;
    } app_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } app_apb_rsp_t;

    typedef struct packed {
        logic [1:0] presc;
        logic       wide;
    } app_cfg_t;

    // Fourth code falls back to the slowest rate
    function automatic logic [2:0] presc_divisor(input logic [1:0] code);
        case (code)
            PRESC_DIV4: presc_divisor = DIVISOR_4;
            PRESC_DIV6: presc_divisor = DIVISOR_6;
            default:    presc_divisor = DIVISOR_7;
        endcase
    endfunction : presc_divisor

    function automatic logic [9:0] period_clocks(input logic [1:0] code);
        case (code)
            PRESC_DIV4: period_clocks = PERIOD_CLOCKS_DIV4;
            PRESC_DIV6: period_clocks = PERIOD_CLOCKS_DIV6;
            default:    period_clocks = PERIOD_CLOCKS_DIV7;
        endcase
    endfunction : period_clocks

    function automatic app_reg_sel_t decode_addr(input logic [APB_ADDR_W-1:0] addr);
        case (addr)
            CTL_ADDR:    decode_addr = SEL_CTL;
            SAMPLE_ADDR: decode_addr = SEL_SAMPLE;
            STATUS_ADDR: decode_addr = SEL_STATUS;
            default:     decode_addr = SEL_NONE;
        endcase
    endfunction : decode_addr

endpackage : app_pkg

/* File: design/app_prescaler.sv */
`timescale 1ns/1ns
module app_prescaler (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset,
    // Control
    input  wire app_pkg::app_cfg_t cfg,
    input  wire logic            restart,
    // Ticks
    output      logic            period_tick,
    output      logic            data_tick
);
    import app_pkg::*;

    logic [2:0] count_reg;
    logic [2:0] count_next;
    logic       half_reg;
    logic       half_next;
    logic [2:0] divisor;
    logic       last_count;

    assign divisor     = presc_divisor(cfg.presc);
    assign last_count  = (count_reg == divisor - 3'h1);
    assign period_tick = ~restart & last_count;
    // Wide mode: every clock at the fastest rate, every other clock otherwise
    assign data_tick   = ~restart & (cfg.wide
                         ? ((cfg.presc == PRESC_DIV4) | half_reg)
                         : last_count);

    assign count_next = (restart | last_count) ? 3'h0 : count_reg + 3'h1;
    assign half_next  = restart ? 1'b0 : ~half_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_reg <= 3'h0;
            half_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            half_reg  <= half_next;
        end
    end

endmodule : app_prescaler

/* File: design/app_pwm.sv */
`timescale 1ns/1ns
// Summary of operation
// - Control: on bit0, rate 3:2, size 5, low bits 7:6
// - Size defaults to 8 bits; bit set gives 10
// - Wide mode appends control 7:6 below sample
// - New sample shows one period later
// - Period counts 128 prescaled ticks, then restarts
// - Prescaler divides by 4, 6 or 7
// - Selected output high at start, then low
// - Sign bit picks positive or negative output
// - Zero magnitude keeps both outputs low
// - Period is 512, 768 or 896 clocks
// - Narrow high time is magnitude times divisor
// - Wide data counter: full or half clock
// - Overlong count holds output high whole period
// - Only divide-by-4 reaches full wide count
// - Off: pulsing stops, both outputs released
// - Pattern repeats until registers change
module app_pwm #(
    parameter int PERIOD_W = app_pkg::PERIOD_W_DEF
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset,
    // APB slave
    input  wire app_pkg::app_apb_req_t apb_req,
    output      app_pkg::app_apb_rsp_t apb_rsp,
    // Push-pull speaker pins
    output      logic                  positive_drive_out,
    output      logic                  positive_drive_oe,
    output      logic                  negative_drive_out,
    output      logic                  negative_drive_oe
);
    import app_pkg::*;

    if (PERIOD_W < 2 || PERIOD_W > 10) begin : g_bad_period
        $error("PERIOD_W must lie between 2 and 10");
    end

    // Registers
    app_state_t           state_reg;
    app_state_t           state_next;
    logic [7:0]           ctl_reg;
    logic [7:0]           ctl_next;
    logic [7:0]           sample_reg;
    logic [7:0]           sample_next;
    app_cfg_t             cfg_reg;
    app_cfg_t             cfg_next;
    logic [PERIOD_W-1:0]  period_reg;
    logic [PERIOD_W-1:0]  period_next;
    logic [MAG_W-1:0]     count_reg;
    logic [MAG_W-1:0]     count_next;
    logic                 sign_reg;
    logic                 sign_next;
    logic                 pos_out_reg;
    logic                 neg_out_reg;
    logic                 pos_oe_reg;
    logic                 neg_oe_reg;
    app_apb_rsp_t         apb_rsp_reg;
    app_apb_rsp_t         apb_rsp_next;

    // Decode and datapath wires
    logic                 setup_phase;
    logic                 access_done;
    app_reg_sel_t         reg_sel;
    logic                 wr_ctl;
    logic                 wr_sample;
    logic [DATA_W-1:0]    rdata_sel;
    logic [DATA_W-1:0]    status_word;
    logic                 turn_on;
    logic                 running;
    logic                 run_next;
    logic                 start;
    logic                 period_tick;
    logic                 data_tick;
    logic                 period_end;
    logic                 boundary;
    logic                 pulse_next;
    logic [MAG_W-1:0]     mag_narrow;
    logic [MAG_W-1:0]     mag_wide;
    logic [MAG_W-1:0]     mag_new;
    logic [9:0]           clk_cnt_reg;

    // APB decode
    assign setup_phase = apb_req.psel & ~apb_req.penable;
    assign access_done = apb_req.psel & apb_req.penable & apb_rsp_reg.pready;
    assign reg_sel     = decode_addr(apb_req.paddr);
    assign wr_ctl      = access_done & apb_req.pwrite & (reg_sel == SEL_CTL);
    assign wr_sample   = access_done & apb_req.pwrite & (reg_sel == SEL_SAMPLE);

    assign ctl_next    = wr_ctl ? apb_req.pwdata[7:0] : ctl_reg;
    assign sample_next = wr_sample ? apb_req.pwdata[7:0] : sample_reg;

    assign status_word = {{(DATA_W-3){1'b0}}, sign_reg, pos_out_reg | neg_out_reg, running};

    always_comb begin
        rdata_sel = '0;
        case (reg_sel)
            SEL_CTL:    rdata_sel = {{(DATA_W-8){1'b0}}, ctl_reg};
            SEL_SAMPLE: rdata_sel = {{(DATA_W-8){1'b0}}, sample_reg};
            SEL_STATUS: rdata_sel = status_word;
            default:    rdata_sel = '0;
        endcase
    end

    // One wait-free access phase: pready rises in the first access cycle
    always_comb begin
        apb_rsp_next.pready  = setup_phase;
        apb_rsp_next.pslverr = setup_phase & (reg_sel == SEL_NONE);
        apb_rsp_next.prdata  = (setup_phase & ~apb_req.pwrite) ? rdata_sel
                                                               : apb_rsp_reg.prdata;
    end

    // Sample magnitude, sign excluded
    assign mag_narrow = {2'h0, sample_reg[SAMPLE_SIGN_BIT-1:0]};
    // Full nine-bit span; slower rates just run out of period first
    assign mag_wide   = {sample_reg[SAMPLE_SIGN_BIT-1:0],
                         ctl_reg[CTL_LSB_HI:CTL_LSB_LO]};
    assign mag_new    = ctl_reg[CTL_WIDE_BIT] ? mag_wide : mag_narrow;

    // Run control
    assign turn_on = ctl_reg[CTL_ON_BIT];
    assign running = (state_reg == ST_RUN);

    always_comb begin
        state_next = state_reg;
        start      = 1'b0;
        case (state_reg)
            ST_OFF: begin
                if (turn_on) begin
                    state_next = ST_RUN;
                    start      = 1'b1;
                end
            end
            ST_RUN: begin
                if (!turn_on) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    assign run_next   = (state_next == ST_RUN);
    assign period_end = running & period_tick & (&period_reg);
    assign boundary   = start | period_end;

    app_prescaler u_prescaler (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .cfg         (cfg_reg),
        // Period end wraps the divider by itself; feeding it back would loop
        .restart     (~running),
        .period_tick (period_tick),
        .data_tick   (data_tick)
    );

    // Mode is taken at the boundary so a period never mixes rates
    assign cfg_next = boundary ? app_cfg_t'{presc: ctl_reg[CTL_PRESC_HI:CTL_PRESC_LO],
                                            wide:  ctl_reg[CTL_WIDE_BIT]}
                               : cfg_reg;

    always_comb begin
        if (!run_next) begin
            period_next = '0;
        end else if (boundary) begin
            period_next = '0;
        end else if (period_tick) begin
            period_next = period_reg + 1'b1;
        end else begin
            period_next = period_reg;
        end
    end

    // Counter reloads every boundary from the live registers
    always_comb begin
        if (!run_next) begin
            count_next = '0;
            sign_next  = 1'b0;
        end else if (boundary) begin
            count_next = mag_new;
            sign_next  = sample_reg[SAMPLE_SIGN_BIT];
        end else if (data_tick && count_reg != '0) begin
            count_next = count_reg - 1'b1;
            sign_next  = sign_reg;
        end else begin
            count_next = count_reg;
            sign_next  = sign_reg;
        end
    end

    // High while the data counter is nonzero, zero stays low
    assign pulse_next = run_next & (count_next != '0);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_reg   <= ST_OFF;
            ctl_reg     <= CTL_RESET;
            sample_reg  <= SAMPLE_RESET;
            cfg_reg     <= '0;
            period_reg  <= '0;
            count_reg   <= '0;
            sign_reg    <= 1'b0;
            apb_rsp_reg <= '0;
        end else begin
            state_reg   <= state_next;
            ctl_reg     <= ctl_next;
            sample_reg  <= sample_next;
            cfg_reg     <= cfg_next;
            period_reg  <= period_next;
            count_reg   <= count_next;
            sign_reg    <= sign_next;
            apb_rsp_reg <= apb_rsp_next;
        end
    end

    // Pins: released when off, pull-ups outside hold them high
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pos_out_reg <= 1'b0;
            neg_out_reg <= 1'b0;
            pos_oe_reg  <= 1'b0;
            neg_oe_reg  <= 1'b0;
        end else begin
            pos_out_reg <= pulse_next & ~sign_next;
            neg_out_reg <= pulse_next & sign_next;
            pos_oe_reg  <= run_next;
            neg_oe_reg  <= run_next;
        end
    end

    assign apb_rsp            = apb_rsp_reg;
    assign positive_drive_out = pos_out_reg;
    assign negative_drive_out = neg_out_reg;
    assign positive_drive_oe  = pos_oe_reg;
    assign negative_drive_oe  = neg_oe_reg;

    // Helper: clocks since the last boundary
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            clk_cnt_reg <= '0;
        end else if (boundary) begin
            clk_cnt_reg <= '0;
        end else begin
            clk_cnt_reg <= clk_cnt_reg + 10'h001;
        end
    end

    AST_CTL_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        (access_done && apb_req.pwrite && reg_sel == SEL_CTL)
        |=> ctl_reg == $past(apb_req.pwdata[7:0]))
        else $error("control write not stored");

    AST_OFF_HIGHZ: assert property (@(posedge sys_clk) disable iff (reset)
        !turn_on |=> (!positive_drive_oe && !negative_drive_oe
                      && !positive_drive_out && !negative_drive_out))
        else $error("outputs driven while unit is off");

    AST_ONE_SIDE: assert property (@(posedge sys_clk) disable iff (reset)
        !(positive_drive_out && negative_drive_out))
        else $error("both outputs high together");

    AST_ZERO_LOW: assert property (@(posedge sys_clk) disable iff (reset)
        (boundary && run_next && mag_new == '0)
        |=> (!positive_drive_out && !negative_drive_out))
        else $error("zero sample produced a pulse");

    AST_NEG_PULSE: assert property (@(posedge sys_clk) disable iff (reset)
        (boundary && run_next && mag_new != '0 && sample_reg[SAMPLE_SIGN_BIT])
        |=> (negative_drive_out && !positive_drive_out))
        else $error("negative sample did not pulse negative output");

    AST_WIDTH_8BIT: assert property (@(posedge sys_clk) disable iff (reset)
        (boundary && run_next && !ctl_reg[CTL_WIDE_BIT]
         && ctl_reg[CTL_PRESC_HI:CTL_PRESC_LO] == PRESC_DIV4
         && sample_reg == 8'h01)
        |=> positive_drive_out [*4] ##1 !positive_drive_out)
        else $error("narrow unit pulse not four clocks");

    AST_WIDTH_10BIT: assert property (@(posedge sys_clk) disable iff (reset)
        (boundary && run_next && ctl_reg[CTL_WIDE_BIT]
         && ctl_reg[CTL_PRESC_HI:CTL_PRESC_LO] == PRESC_DIV6
         && sample_reg == 8'h00 && ctl_reg[CTL_LSB_HI:CTL_LSB_LO] == 2'h1)
        |=> positive_drive_out [*2] ##1 !positive_drive_out)
        else $error("wide unit pulse not two clocks at divide-by-6");

    AST_PERIOD_LEN: assert property (@(posedge sys_clk) disable iff (reset)
        (period_end && PERIOD_W == PERIOD_W_DEF)
        |-> clk_cnt_reg == period_clocks(cfg_reg.presc) - 10'h001)
        else $error("sample period length wrong");

    AST_HOLD: assert property (@(posedge sys_clk) disable iff (reset)
        (running && run_next && !boundary && !data_tick) |=> $stable(count_reg))
        else $error("data counter moved without a tick");

    AST_SATURATE: assert property (@(posedge sys_clk) disable iff (reset)
        (period_end && run_next && count_reg != '0 && mag_new != '0)
        |-> (positive_drive_out || negative_drive_out)
            ##1 (positive_drive_out || negative_drive_out))
        else $error("saturated pulse dropped at period boundary");

    AST_WIDE_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
        (boundary && run_next && ctl_reg[CTL_WIDE_BIT])
        |=> (count_reg[1:0] == $past(ctl_reg[CTL_LSB_HI:CTL_LSB_LO])
             && count_reg[MAG_W-1:2] == $past(sample_reg[SAMPLE_SIGN_BIT-1:0])))
        else $error("wide sample not assembled");

endmodule : app_pwm

/* File: verif/app_speaker_model.sv */
`timescale 1ns/1ns
module app_speaker_model (
    // Drive pins from the block
    input  wire logic pos_out,
    input  wire logic pos_oe,
    input  wire logic neg_out,
    input  wire logic neg_oe,
    // Resolved speaker terminals
    output wire logic pos_level,
    output wire logic neg_level
);
    // Released pins float up through the pull-ups
    assign pos_level = pos_oe ? pos_out : 1'b1;
    assign neg_level = neg_oe ? neg_out : 1'b1;
endmodule : app_speaker_model

/* File: verif/push_pull_audio_pwm_tb_top.sv */
`timescale 1ns/1ns
module push_pull_audio_pwm_tb_top;
    import app_pkg::*;
    logic         sys_clk  = 1'b0;
    logic         reset    = 1'b1;
    app_apb_req_t apb_req  = '0;
    app_apb_rsp_t apb_rsp;
    logic         pos_out;
    logic         pos_oe;
    logic         neg_out;
    logic         neg_oe;
    logic         pos_level;
    logic         neg_level;
    int           errors   = 0;
    int           compares = 0;
    logic [31:0]  seed     = 32'h0000_0026;
    logic [31:0]  rd;
    logic         err;
    logic [7:0]   tctl [10] = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'hE1, 8'h65, 8'hE9, 8'h25, 8'h01, 8'h05};
    logic [7:0]   tsmp [10] = '{8'h01, 8'h7F, 8'h81, 8'h85, 8'h7F, 8'h00, 8'h6F, 8'h7F, 8'h00, 8'h80};

    always #5 sys_clk = ~sys_clk;

    app_pwm app_pwm_inst (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .apb_req            (apb_req),
        .apb_rsp            (apb_rsp),
        .positive_drive_out (pos_out),
        .positive_drive_oe  (pos_oe),
        .negative_drive_out (neg_out),
        .negative_drive_oe  (neg_oe)
    );

    app_speaker_model app_speaker_model_inst (
        .pos_out   (pos_out),
        .pos_oe    (pos_oe),
        .neg_out   (neg_out),
        .neg_oe    (neg_oe),
        .pos_level (pos_level),
        .neg_level (neg_level)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int divisor(input logic [7:0] ctl);
        return (ctl[3:2] == 2'h0) ? 4 : (ctl[3:2] == 2'h1) ? 6 : 7;
    endfunction : divisor

    function automatic int high_time(input logic [7:0] ctl, input logic [7:0] smp);
        int t;
        if (ctl[5]) begin
            t = {smp[6:0], ctl[7:6]} * ((divisor(ctl) == 4) ? 1 : 2);
        end else begin
            t = smp[6:0] * divisor(ctl);
        end
        return (t > 128 * divisor(ctl)) ? 128 * divisor(ctl) : t;
    endfunction : high_time

    function automatic logic lvl(input logic neg);
        return neg ? neg_level : pos_level;
    endfunction : lvl

    // Master waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wd;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (apb_rsp.pready !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t bus answer timed out", $time);
        end
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic measure(input logic [7:0] ctl, input logic [7:0] smp);
        int   h;
        int   len;
        int   per;
        int   exp_h;
        logic other;
        per   = 128 * divisor(ctl);
        exp_h = high_time(ctl, smp);
        h     = 0;
        len   = 0;
        other = 1'b0;
        if (exp_h == 0 || exp_h == per) begin
            repeat (2 * per) begin
                @(negedge sys_clk);
                h     += (lvl(smp[7]) === 1'b1);
                other |= (lvl(~smp[7]) !== 1'b0);
            end
            check(h, exp_h ? 2 * per : 0);
        end else begin
            // Align to the start of a pulse: fall first, then rise
            while (lvl(smp[7]) !== 1'b0 && len < 2000) begin
                @(negedge sys_clk);
                len++;
            end
            while (lvl(smp[7]) !== 1'b1 && len < 4000) begin
                @(negedge sys_clk);
                len++;
            end
            len = 0;
            while (lvl(smp[7]) === 1'b1 && h < 2000) begin
                h++;
                other |= (lvl(~smp[7]) !== 1'b0);
                @(negedge sys_clk);
            end
            len = h;
            while (lvl(smp[7]) !== 1'b1 && len < 2000) begin
                len++;
                other |= (lvl(~smp[7]) !== 1'b0);
                @(negedge sys_clk);
            end
            check(h, exp_h);
            check(len, per);
        end
        check(other, 1'b0);
    endtask : measure

    task automatic run(input logic [7:0] ctl, input logic [7:0] smp);
        apb(1'b1, SAMPLE_ADDR, {24'h0, smp});
        apb(1'b1, CTL_ADDR, {24'h0, ctl});
        // Let the new values reach a period boundary first
        repeat (900) @(posedge sys_clk);
        measure(ctl, smp);
    endtask : run

    initial begin
        logic [7:0] c;
        logic [7:0] s;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        apb(1'b0, CTL_ADDR, 32'h0);
        check(rd, {24'h0, CTL_RESET});
        apb(1'b0, SAMPLE_ADDR, 32'h0);
        check(rd, {24'h0, SAMPLE_RESET});
        check({pos_level, neg_level}, 2'h3);
        apb(1'b1, CTL_ADDR, 32'hFFFF_FFEC);
        apb(1'b0, CTL_ADDR, 32'h0);
        check(rd, 32'h0000_00EC);
        check({pos_level, neg_level}, 2'h3);
        apb(1'b0, 12'hFFC, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 10; i++) begin
            run(tctl[i], tsmp[i]);
        end
        repeat (4) begin
            c = 8'(rnd());
            s = 8'(rnd());
            c = (c & 8'hEC) | 8'h01;
            if (c[5] && c[3:2] != 2'h0 && s[6:0] > 7'h6F) begin
                s[6:0] = 7'h6F;
            end
            run(c, s);
        end
        run(8'h01, 8'h04);
        fork
            measure(8'h01, 8'h04);
            begin
                @(posedge pos_level);
                apb(1'b1, SAMPLE_ADDR, 32'h0000_0008);
            end
        join
        measure(8'h01, 8'h08);
        apb(1'b1, CTL_ADDR, 32'h0);
        repeat (3) @(negedge sys_clk);
        check({pos_level, neg_level}, 2'h3);
        repeat (600) @(negedge sys_clk);
        check({pos_level, neg_level}, 2'h3);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, 32'h0);
        wrap_up();
    end

    initial begin
        repeat (90000) @(posedge sys_clk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : push_pull_audio_pwm_tb_top
